// ==== fsbp_status_protect.sv ====
// Status register, write protection and block protection behind the serial port
// Function
// - Status register is read and written by read-status and write-status commands.
// - Write-disable bit set with protect pin low makes status read-only.
// - Hardware-protected mode ends only when the protect pin goes high.
// - Bit 7 is write-disable, cleared by reset like the other bits; 0 permits status writes.
// - Bit 5 selects protected region at top (0, default) or bottom (1).
// - Block-protect bits at 6 and 4:2; program/erase to protected sectors rejected.
// - Write enable latch bit 1 clears at power-up, set by write-enable.
// - Bit 0 reads busy during write-status, program or erase cycles.
// - Whole-array erase runs only when all block-protect bits are zero.
// - Status bit 0 always equals inverse of flag status ready bit.
// - Protect code n covers 2^(n-1) sectors from chosen end; 9+ covers all.
// - 24-bit addresses map to 256 aligned 64KB sectors and aligned subsectors.
// - Protection error flag sets when program or erase hits a protected sector.
`timescale 1ns/1ns
`default_nettype none
module fsbp_status_protect
  import fsbp_pkg::*;
#(
  parameter logic [BUSY_W-1:0] BUSY_CYCLES = 16'h0040
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic SCK,
  input wire logic CS_B,
  input wire logic DQ0_IN,
  input wire logic W_B,
  output logic DQ1_OUT,
  output logic DQ1_OE,
  output logic [7:0] STATUS,
  output logic [7:0] FLAG_STATUS
);
  fsbp_state_t s;
  fsbp_state_t next_s;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic frame_end;
  logic hw_locked;
  logic is_sector_erase;
  logic sector_locked;
  logic wrsr_end;
  logic wren_end;
  logic erase_end;
  logic bulk_end;
  logic [7:0] sr_value;
  logic [7:0] fs_value;
  logic [7:0] rx_byte;
  logic [SECTOR_W-1:0] target_sector;

  assign sck_rise = s.sy.sck[1] && !s.sy.sck_prev;
  assign sck_fall = !s.sy.sck[1] && s.sy.sck_prev;
  assign frame_start = !s.sy.cs_b[1] && s.sy.cs_prev;
  assign frame_end = s.sy.cs_b[1] && !s.sy.cs_prev;
  assign hw_locked = s.srwd && !s.sy.wp_b[1];
  assign is_sector_erase = (s.cmd == CMD_SE64) || (s.cmd == CMD_SE32) || (s.cmd == CMD_SE4);
  assign target_sector = s.addr[SECTOR_LSB +: SECTOR_W];
  assign rx_byte = {s.shift[6:0], s.sy.din[1]};
  assign wrsr_end = frame_end && (s.cmd == CMD_WRSR) && (s.phase == ST_DATA) && s.got_data && !s.busy;
  assign wren_end = frame_end && (s.cmd == CMD_WREN) && (s.phase == ST_SKIP) && !s.busy;
  assign erase_end = frame_end && is_sector_erase && (s.phase == ST_SKIP) && !s.busy;
  assign bulk_end = frame_end && (s.cmd == CMD_BE) && (s.phase == ST_SKIP) && !s.busy;

  fsbp_sector_guard u_guard (
    .protect_span_bits(s.bp),
    .from_bottom(s.tb),
    .sector(target_sector),
    .locked(sector_locked)
  );

  always_comb begin
    sr_value = 8'h00;
    sr_value[SR_SRWD] = s.srwd;
    sr_value[SR_BP3] = s.bp[3];
    sr_value[SR_TB] = s.tb;
    sr_value[SR_BP2 -: 3] = s.bp[2:0];
    sr_value[SR_WEL] = s.wel;
    sr_value[SR_WIP] = s.busy;
    fs_value = 8'h00;
    fs_value[FS_READY] = !s.busy;
    fs_value[FS_ERASE] = s.err_erase;
    fs_value[FS_PROG] = s.err_prog;
    fs_value[FS_PROT] = s.err_prot;
  end

  assign STATUS = sr_value;
  assign FLAG_STATUS = fs_value;
  assign DQ1_OUT = s.dout;
  assign DQ1_OE = s.oe;

  always_comb begin
    next_s = s;
    next_s.sy.sck = {s.sy.sck[0], SCK};
    next_s.sy.cs_b = {s.sy.cs_b[0], CS_B};
    next_s.sy.din = {s.sy.din[0], DQ0_IN};
    next_s.sy.wp_b = {s.sy.wp_b[0], W_B};
    next_s.sy.sck_prev = s.sy.sck[1];
    next_s.sy.cs_prev = s.sy.cs_b[1];
    // Cycle timer of write-status, program and erase
    if (s.busy) begin
      next_s.busy_cnt = s.busy_cnt - BUSY_LAST;
      if (s.busy_cnt == BUSY_LAST) begin
        next_s.busy = 1'b0;
      end
    end
    if (frame_start) begin
      next_s.phase = ST_CMD;
      next_s.cnt = 5'h00;
      next_s.cmd = CMD_NONE;
      next_s.got_data = 1'b0;
    end else if (!s.sy.cs_b[1] && sck_rise) begin
      next_s.shift = rx_byte;
      next_s.cnt = s.cnt + 5'h01;
      unique case (s.phase)
        ST_CMD: begin
          if (s.cnt == LAST_BYTE_BIT) begin
            next_s.cnt = 5'h00;
            next_s.cmd = rx_byte;
            next_s.tx_cnt = 3'h0;
            if (rx_byte == CMD_RDSR) begin
              next_s.phase = ST_READ;
              next_s.tx = sr_value;
              next_s.oe = 1'b1;
            end else if (rx_byte == CMD_RDFS) begin
              next_s.phase = ST_READ;
              next_s.tx = fs_value;
              next_s.oe = 1'b1;
            end else if (rx_byte == CMD_WRSR) begin
              next_s.phase = ST_DATA;
            end else if ((rx_byte == CMD_PP) || (rx_byte == CMD_SE64) || (rx_byte == CMD_SE32) ||
                         (rx_byte == CMD_SE4)) begin
              next_s.phase = ST_ADDR;
            end else begin
              next_s.phase = ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          next_s.addr = {s.addr[ADDR_W-2:0], s.sy.din[1]};
          if (s.cnt == LAST_ADDR_BIT) begin
            next_s.cnt = 5'h00;
            next_s.phase = (s.cmd == CMD_PP) ? ST_DATA : ST_SKIP;
          end
        end
        ST_DATA: begin
          if (s.cnt == LAST_BYTE_BIT) begin
            next_s.cnt = 5'h00;
            next_s.got_data = 1'b1;
            if (!s.got_data) begin
              next_s.wdata = rx_byte;
            end
          end
        end
        ST_READ, ST_SKIP: begin
          next_s.cnt = 5'h00;
        end
        default: begin
          next_s.phase = ST_SKIP;
        end
      endcase
    end
    // Read data shifts out on the falling serial clock, repeating the fresh value
    if (!s.sy.cs_b[1] && sck_fall && (s.phase == ST_READ)) begin
      next_s.dout = s.tx[7];
      if (s.tx_cnt == LAST_TX_BIT) begin
        next_s.tx_cnt = 3'h0;
        next_s.tx = (s.cmd == CMD_RDSR) ? sr_value : fs_value;
      end else begin
        next_s.tx_cnt = s.tx_cnt + 3'h1;
        next_s.tx = {s.tx[6:0], 1'b0};
      end
    end
    if (frame_end) begin
      next_s.oe = 1'b0;
      next_s.phase = ST_SKIP;
      if (wren_end) begin
        next_s.wel = 1'b1;
      end
      if ((s.cmd == CMD_WRDI) && (s.phase == ST_SKIP) && !s.busy) begin
        next_s.wel = 1'b0;
      end
      if (wrsr_end) begin
        next_s.wel = 1'b0;
        if (s.wel && !hw_locked) begin
          next_s.srwd = s.wdata[SR_SRWD];
          next_s.bp = {s.wdata[SR_BP3], s.wdata[SR_BP2 -: 3]};
          next_s.tb = s.wdata[SR_TB];
          next_s.busy = 1'b1;
          next_s.busy_cnt = BUSY_CYCLES;
        end
      end
      if ((s.cmd == CMD_PP) && (s.phase == ST_DATA) && s.got_data && !s.busy && s.wel) begin
        next_s.wel = 1'b0;
        if (sector_locked) begin
          next_s.err_prot = 1'b1;
          next_s.err_prog = 1'b1;
        end else begin
          next_s.busy = 1'b1;
          next_s.busy_cnt = BUSY_CYCLES;
        end
      end
      if (erase_end && s.wel) begin
        next_s.wel = 1'b0;
        if (sector_locked) begin
          next_s.err_prot = 1'b1;
          next_s.err_erase = 1'b1;
        end else begin
          next_s.busy = 1'b1;
          next_s.busy_cnt = BUSY_CYCLES;
        end
      end
      if (bulk_end && s.wel) begin
        next_s.wel = 1'b0;
        if (s.bp != SPAN_NONE) begin
          next_s.err_prot = 1'b1;
          next_s.err_erase = 1'b1;
        end else begin
          next_s.busy = 1'b1;
          next_s.busy_cnt = BUSY_CYCLES;
        end
      end
      if ((s.cmd == CMD_CLFS) && (s.phase == ST_SKIP)) begin
        next_s.err_prot = 1'b0;
        next_s.err_prog = 1'b0;
        next_s.err_erase = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= FSBP_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  property p_wip_inverse;
    @(posedge REF_CLK) disable iff (!RST_B) STATUS[SR_WIP] == !FLAG_STATUS[FS_READY];
  endproperty
  a_wip_inverse: assert property (p_wip_inverse) else $error("wip not inverse of ready");

  property p_hw_lock;
    @(posedge REF_CLK) disable iff (!RST_B)
      (wrsr_end && hw_locked) |=> (!s.busy && $stable(s.bp) && $stable(s.tb) && s.srwd);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("status written while locked");

  property p_lock_hold;
    @(posedge REF_CLK) disable iff (!RST_B) (s.srwd && !s.sy.wp_b[1]) |=> s.srwd;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock released without pin");

  property p_wel_clear;
    @(posedge REF_CLK) disable iff (!RST_B) wrsr_end |=> !STATUS[SR_WEL];
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("wel kept after status write");

  property p_wel_rise;
    @(posedge REF_CLK) disable iff (!RST_B) $rose(s.wel) |-> $past(wren_end);
  endproperty
  a_wel_rise: assert property (p_wel_rise) else $error("wel set without write enable");

  property p_wip_set;
    @(posedge REF_CLK) disable iff (!RST_B)
      (wrsr_end && s.wel && !hw_locked) |=> STATUS[SR_WIP] ##1 STATUS[SR_WIP];
  endproperty
  a_wip_set: assert property (p_wip_set) else $error("busy missing after status write");

  property p_bulk_block;
    @(posedge REF_CLK) disable iff (!RST_B)
      (bulk_end && s.wel && (s.bp != SPAN_NONE)) |=> (!s.busy && s.err_prot && s.err_erase);
  endproperty
  a_bulk_block: assert property (p_bulk_block) else $error("bulk erase ran while protected");

  property p_prot_reject;
    @(posedge REF_CLK) disable iff (!RST_B)
      (erase_end && s.wel && sector_locked) |=> (!s.busy && FLAG_STATUS[FS_PROT]);
  endproperty
  a_prot_reject: assert property (p_prot_reject) else $error("protected erase not rejected");

  property p_decode_none;
    @(posedge REF_CLK) disable iff (!RST_B) (s.bp == SPAN_NONE) |-> !sector_locked;
  endproperty
  a_decode_none: assert property (p_decode_none) else $error("sector locked with code zero");

  property p_decode_all;
    @(posedge REF_CLK) disable iff (!RST_B) (s.bp > SPAN_MAX_PART) |-> sector_locked;
  endproperty
  a_decode_all: assert property (p_decode_all) else $error("sector open with full code");

  property p_decode_half;
    @(posedge REF_CLK) disable iff (!RST_B)
      (s.bp == SPAN_MAX_PART) |-> (sector_locked == (s.tb ? !target_sector[SECTOR_W-1] : target_sector[SECTOR_W-1]));
  endproperty
  a_decode_half: assert property (p_decode_half) else $error("half array decode wrong");
endmodule // fsbp_status_protect
`default_nettype wire

// ==== fsbp_pkg.sv ====
// Shared constants and types for the status register and block protection logic
`default_nettype none
package fsbp_pkg;
  // Serial command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_RDFS = 8'h70;
  localparam logic [7:0] CMD_CLFS = 8'h50;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE64 = 8'hD8;
  localparam logic [7:0] CMD_SE32 = 8'h52;
  localparam logic [7:0] CMD_SE4 = 8'h20;
  localparam logic [7:0] CMD_BE = 8'hC7;
  // Status register bit positions
  localparam int SR_SRWD = 7;
  localparam int SR_BP3 = 6;
  localparam int SR_TB = 5;
  localparam int SR_BP2 = 4;
  localparam int SR_BP0 = 2;
  localparam int SR_WEL = 1;
  localparam int SR_WIP = 0;
  // Flag status register bit positions
  localparam int FS_READY = 7;
  localparam int FS_ERASE = 5;
  localparam int FS_PROG = 4;
  localparam int FS_PROT = 1;
  // Address map
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W = 8;
  localparam int SUB32_LSB = 15;
  localparam int SUB4_LSB = 12;
  localparam logic [8:0] SECTOR_COUNT = 9'h100;
  // Block protect codes
  localparam logic [3:0] SPAN_NONE = 4'h0;
  localparam logic [3:0] SPAN_ONE = 4'h1;
  localparam logic [3:0] SPAN_MAX_PART = 4'h8;
  // Serial bit counts and busy timer width and last count
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
  localparam logic [2:0] LAST_TX_BIT = 3'h7;
  localparam int BUSY_W = 16;
  localparam logic [BUSY_W-1:0] BUSY_LAST = 16'h0001;

  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA, ST_READ, ST_SKIP} fsbp_phase_t;

  // Two-stage synchronisers: bit 0 first stage, bit 1 second stage
  typedef struct packed {
    logic [1:0] sck;
    logic [1:0] cs_b;
    logic [1:0] din;
    logic [1:0] wp_b;
    logic sck_prev;
    logic cs_prev;
  } fsbp_sync_t;

  typedef struct packed {
    fsbp_sync_t sy;
    fsbp_phase_t phase;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [7:0] shift;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic got_data;
    logic [7:0] tx;
    logic [2:0] tx_cnt;
    logic dout;
    logic oe;
    logic srwd;
    logic [3:0] bp;
    logic tb;
    logic wel;
    logic busy;
    logic [BUSY_W-1:0] busy_cnt;
    logic err_erase;
    logic err_prog;
    logic err_prot;
  } fsbp_state_t;

  // Chip select idles high: its synchroniser starts there, so no false frame end follows reset
  localparam fsbp_sync_t SYNC_RST = '{sck: 2'h0, cs_b: 2'h3, din: 2'h0, wp_b: 2'h0, sck_prev: 1'h0, cs_prev: 1'h1};
  localparam fsbp_state_t FSBP_STATE_RST =
    fsbp_state_t'({SYNC_RST, {($bits(fsbp_state_t) - $bits(fsbp_sync_t)){1'h0}}});
endpackage
`default_nettype wire

// ==== fsbp_sector_guard.sv ====
// Decoder of the protected 64KB sector range
`timescale 1ns/1ns
`default_nettype none
module fsbp_sector_guard
  import fsbp_pkg::*;
(
  input wire logic [3:0] protect_span_bits,
  input wire logic from_bottom,
  input wire logic [SECTOR_W-1:0] sector,
  output logic locked
);
  logic [8:0] span_count;
  logic [8:0] sector_ext;

  always_comb begin
    sector_ext = {1'b0, sector};
    if (protect_span_bits == SPAN_NONE) begin
      span_count = 9'h000;
    end else if (protect_span_bits > SPAN_MAX_PART) begin
      span_count = SECTOR_COUNT;
    end else begin
      span_count = 9'h001 << (protect_span_bits - SPAN_ONE);
    end
    if (from_bottom) begin
      locked = sector_ext < span_count;
    end else begin
      locked = (span_count != 9'h000) && (sector_ext >= (SECTOR_COUNT - span_count));
    end
  end
endmodule // fsbp_sector_guard
`default_nettype wire

// ==== fsbp_host_model.sv ====
// Serial host model that frames commands and collects read bytes
`timescale 1ns/1ns
`default_nettype none
module fsbp_host_model (
  input wire logic ref_clk,
  input wire logic dq1_out,
  input wire logic dq1_oe,
  output logic sck,
  output logic cs_b,
  output logic dq0_in,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    dq0_in = 1'b0;
    rd_data = 8'h00;
    rd_valid = 1'b0;
  end

  // Link clock only toggles inside frames, 320 ns period
  task automatic frame(input logic [39:0] bits, input int nbits, input logic rd);
    logic [7:0] sh;
    sh = 8'h00;
    @(posedge ref_clk) #1;
    cs_b = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      dq0_in = bits[39-i];
      repeat (4) @(posedge ref_clk);
      // Undriven data line shows the inverse of its last level
      #1 sh = {sh[6:0], dq1_oe ? dq1_out : ~dq1_out};
      sck = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 sck = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    #1 cs_b = 1'b1;
    // Released line must not keep its last level
    dq0_in = ~dq0_in;
    if (rd) begin
      rd_data = sh;
      rd_valid = 1'b1;
    end
    @(posedge ref_clk) #1 rd_valid = 1'b0;
    repeat (15) @(posedge ref_clk);
    #1;
  endtask
endmodule // fsbp_host_model
`default_nettype wire

// ==== test_flash_status_block_protect.sv ====
// Self-checking bench for status register and block protection
`timescale 1ns/1ns
`default_nettype none
module test_flash_status_block_protect;
  import fsbp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic w_b = 1'b1;
  logic sck, cs_b, dq0_in, dq1_out, dq1_oe, rd_valid;
  logic [7:0] status, flag_status, rd_data;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;

  always #20 ref_clk = ~ref_clk;

  fsbp_status_protect #(.BUSY_CYCLES(16'h0040)) dut_u (
    .REF_CLK(ref_clk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b), .DQ0_IN(dq0_in), .W_B(w_b),
    .DQ1_OUT(dq1_out), .DQ1_OE(dq1_oe), .STATUS(status), .FLAG_STATUS(flag_status)
  );

  fsbp_host_model host_u (
    .ref_clk(ref_clk), .dq1_out(dq1_out), .dq1_oe(dq1_oe), .sck(sck), .cs_b(cs_b), .dq0_in(dq0_in),
    .rd_data(rd_data), .rd_valid(rd_valid)
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic send(input logic [39:0] bits, input int nbits);
    host_u.frame(bits, nbits, 1'b0);
  endtask

  task automatic rd_reg(input logic [7:0] cmd, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.frame({cmd, 32'h0}, 16, 1'b1);
  endtask

  task automatic wrsr(input logic [7:0] v);
    send({CMD_WREN, 32'h0}, 8);
    send({CMD_WRSR, v, 24'h0}, 16);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (status[SR_WIP] !== 1'b0 && n < 200) begin
      @(posedge ref_clk) #1;
      n++;
    end
    chk("ready", 8'h00, {7'h0, status[SR_WIP]});
  endtask

  function automatic int span(input logic [3:0] n);
    return (n == 4'h0) ? 0 : (n > 4'h8) ? 256 : (1 << (n - 4'h1));
  endfunction

  // Read results checked in order of request
  always @(posedge ref_clk) begin
    if (rd_valid)
      chk("serial read", exp_q.pop_front(), rd_data);
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0] v, s;
    logic [3:0] n;
    logic lk;
    int c, k, seed;
    seed = $urandom(5);
    repeat (10) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("status at reset", 8'h00, status);
    chk("flag at reset", 8'h80, flag_status);
    rd_reg(CMD_RDSR, 8'h00);
    send({CMD_WRSR, 8'h7C, 24'h0}, 16);
    rd_reg(CMD_RDSR, 8'h00);
    send({CMD_WREN, 32'h0}, 8);
    rd_reg(CMD_RDSR, 8'h02);
    send({CMD_WRDI, 32'h0}, 8);
    rd_reg(CMD_RDSR, 8'h00);
    $display("test write enable done");
    for (int i = 0; i < 32; i++) begin
      n = i[3:0];
      c = span(n);
      v = {1'b0, n[3], i[4], n[2:0], 2'($urandom)};
      w_b = 1'($urandom);
      wrsr(v);
      chk("busy", 8'h01, {7'h0, status[SR_WIP]});
      chk("flag busy", 8'h00, {7'h0, flag_status[FS_READY]});
      wait_ready();
      rd_reg(CMD_RDSR, {v[7:2], 2'b00});
      case (i % 3)
        0: s = 8'(i[4] ? c - 1 : 256 - c);
        1: s = 8'(i[4] ? c : 255 - c);
        default: s = 8'($urandom);
      endcase
      k = i % 5;
      lk = (k == 4) ? (n != 4'h0) : (i[4] ? (int'(s) < c) : (int'(s) >= 256 - c));
      send({CMD_WREN, 32'h0}, 8);
      case (k)
        0: send({CMD_SE64, s, 16'($urandom), 8'h00}, 32);
        1: send({CMD_SE32, s, 16'($urandom), 8'h00}, 32);
        2: send({CMD_SE4, s, 16'($urandom), 8'h00}, 32);
        3: send({CMD_PP, s, 16'($urandom), 8'($urandom)}, 40);
        default: send({CMD_BE, 32'h0}, 8);
      endcase
      wait_ready();
      rd_reg(CMD_RDFS, lk ? ((k == 3) ? 8'h92 : 8'hA2) : 8'h80);
      send({CMD_CLFS, 32'h0}, 8);
    end
    $display("test protection map done");
    w_b = 1'b1;
    wrsr(8'h80);
    wait_ready();
    rd_reg(CMD_RDSR, 8'h80);
    w_b = 1'b0;
    wrsr(8'h1C);
    chk("refused busy", 8'h00, {7'h0, status[SR_WIP]});
    rd_reg(CMD_RDSR, 8'h80);
    send({CMD_CLFS, 32'h0}, 8);
    wrsr(8'h00);
    rd_reg(CMD_RDSR, 8'h80);
    w_b = 1'b1;
    wrsr(8'h00);
    wait_ready();
    rd_reg(CMD_RDSR, 8'h00);
    $display("test hardware protect done");
    repeat (20) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule // test_flash_status_block_protect
`default_nettype wire
